// ### verilog/shifter_pkg.sv
/*
 * Shared constants of the eight-stage parallel-in, serial-out shifter.
 * Assumes nothing beyond a SystemVerilog package scope.
 */
package shifter_pkg;

    // ------------------------------------------------------------
    // register geometry
    // ------------------------------------------------------------
    localparam int STAGE_COUNT = 8;
    localparam int FIRST_IDX = 0;
    localparam int LAST_IDX = STAGE_COUNT - 1;
    localparam logic [STAGE_COUNT-1:0] CLEAR_VALUE = 8'h00;

    // ------------------------------------------------------------
    // output buffer geometry and gated clock sample reset value
    // ------------------------------------------------------------
    localparam int BUF_DEPTH = 2;
    localparam int BUF_WIDTH = 1;
    localparam logic GATE_OR_RESET = 1'b1;

endpackage

// ### verilog/bit_stream_if.sv
/*
 * Valid/ready stream carrying one output word between internal modules.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface bit_stream_if;
    logic valid;
    logic ready;
    logic [shifter_pkg::BUF_WIDTH-1:0] data;

    // producer drives valid and data
    modport source (
        output valid,
        output data,
        input ready
    );

    // consumer drives ready
    modport sink (
        input valid,
        input data,
        output ready
    );
endinterface

// ### verilog/two_entry_buffer.sv
/*
 * Two-entry flip-flop FIFO with valid and ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps

module two_entry_buffer (
    input wire logic sys_clk,
    input wire logic rst_n,
    bit_stream_if.sink fill,
    bit_stream_if.source drain
);

    // ------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------
    logic [shifter_pkg::BUF_WIDTH-1:0] mem [shifter_pkg::BUF_DEPTH];
    logic [shifter_pkg::BUF_WIDTH-1:0] next_mem [shifter_pkg::BUF_DEPTH];
    logic wr_idx;
    logic next_wr_idx;
    logic rd_idx;
    logic next_rd_idx;
    logic [1:0] count;
    logic [1:0] next_count;
    logic push;
    logic pop;

    // honest full and empty flags
    assign fill.ready = (count != 2'(shifter_pkg::BUF_DEPTH));
    assign drain.valid = (count != 2'h0);
    assign drain.data = mem[rd_idx];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    // next pointer, count and storage values
    always_comb begin
        next_mem = mem;
        next_wr_idx = wr_idx;
        next_rd_idx = rd_idx;
        next_count = count;
        if (push) begin
            next_mem[wr_idx] = fill.data;
            next_wr_idx = ~wr_idx;
        end
        if (pop) begin
            next_rd_idx = ~rd_idx;
        end
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    // register the buffer state
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < shifter_pkg::BUF_DEPTH; i++) begin
                mem[i] <= '0;
            end
            wr_idx <= 1'b0;
            rd_idx <= 1'b0;
            count <= 2'h0;
        end else begin
            mem <= next_mem;
            wr_idx <= next_wr_idx;
            rd_idx <= next_rd_idx;
            count <= next_count;
        end
    end

endmodule

// ### verilog/parallel_in_serial_out_shifter.sv
/*
 * Eight-stage parallel-in, serial-out shift register with a gated clock,
 * a clear input and a two-entry buffer of the bits shown on serial_out.
 * Assumes every pin input is synchronous to sys_clk and that sys_clk
 * samples each level of clk_pin and clk_gate_n at least once.
 * A gate rise while clk_pin is low counts as an active edge, so the
 * controlling logic must keep to the gate ordering rule.
 * A bit that meets a full buffer is lost; bit_room warns of that.
 */
`timescale 1ns/1ps

// Functional notes
// R1 - eight stages, last stage drives serial_out
// R2 - load select low: copy parallel inputs
// R3 - load select high: shift, serial_in enters
// R4 - chain serial_out into next serial_in
// R5 - clock is OR of pin and gate
// R6 - pin and gate are interchangeable
// R7 - gate rises only while clock high
// R8 - clear low zeroes stages, overrides all
// R9 - no active edge: stages hold
// R10 - after clear, resume at next edge
module parallel_in_serial_out_shifter (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_pin,
    input wire logic clk_gate_n,
    input wire logic load_select_n,
    input wire logic serial_in,
    input wire logic [shifter_pkg::STAGE_COUNT-1:0] par_in,
    input wire logic clear_n,
    output logic serial_out,
    output logic bit_room,
    output logic bit_valid,
    output logic bit_data,
    input wire logic bit_ready
);

    // ------------------------------------------------------------
    // gated clock edge detection
    // ------------------------------------------------------------
    logic gate_or;
    logic or_prev;
    logic next_or_prev;
    logic edge_hit;

    // either input may act as clock or enable
    assign gate_or = clk_pin | clk_gate_n; // see R5, see R6
    assign edge_hit = gate_or && !or_prev; // see R5

    // next value of the sampled gated clock
    always_comb begin
        next_or_prev = gate_or;
    end

    // keeps tracking during clear so the next edge is seen
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            or_prev <= shifter_pkg::GATE_OR_RESET;
        end else begin
            or_prev <= next_or_prev; // see R10
        end
    end

    // ------------------------------------------------------------
    // stage register
    // ------------------------------------------------------------
    logic [shifter_pkg::STAGE_COUNT-1:0] stage;
    logic [shifter_pkg::STAGE_COUNT-1:0] next_stage;

    // clear first, then load or shift on an edge, else hold
    always_comb begin
        next_stage = stage; // see R9
        if (!clear_n) begin
            next_stage = shifter_pkg::CLEAR_VALUE; // see R8
        end else if (edge_hit) begin
            if (!load_select_n) begin
                next_stage = par_in; // see R2
            end else begin
                next_stage = {stage[shifter_pkg::LAST_IDX-1:0],
                    serial_in}; // see R3
            end
        end
    end

    // register the stages
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stage <= shifter_pkg::CLEAR_VALUE;
        end else begin
            stage <= next_stage;
        end
    end

    // last stage out, forced low at once while clearing
    assign serial_out = clear_n
        && stage[shifter_pkg::LAST_IDX]; // see R1, see R8

    // ------------------------------------------------------------
    // buffer of bits presented after each active edge
    // ------------------------------------------------------------
    bit_stream_if push_if ();
    bit_stream_if pop_if ();

    // each accepted edge offers the new last-stage bit
    assign push_if.valid = clear_n && edge_hit;
    assign push_if.data = next_stage[shifter_pkg::LAST_IDX];
    assign bit_room = push_if.ready;
    assign bit_valid = pop_if.valid;
    assign bit_data = pop_if.data;
    assign pop_if.ready = bit_ready;

    two_entry_buffer out_buffer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .fill(push_if.sink),
        .drain(pop_if.source)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_last_stage_out: assert property ( // see R1
        (clear_n && edge_hit && !load_select_n) |=>
            (!clear_n || serial_out == $past(par_in[shifter_pkg::LAST_IDX])))
        else $error("serial_out does not show loaded last input");

    a_parallel_load: assert property ( // see R2
        (clear_n && edge_hit && !load_select_n) |=> stage == $past(par_in))
        else $error("parallel load did not copy inputs");

    a_serial_shift: assert property ( // see R3
        (clear_n && edge_hit && load_select_n) |=>
            stage == {$past(stage[shifter_pkg::LAST_IDX-1:0]),
                $past(serial_in)})
        else $error("shift did not move stages by one");

    a_gate_blocks_clock: assert property ( // see R5
        (clear_n && clk_gate_n && or_prev) |=> $stable(stage))
        else $error("stages moved while clock gate high");

    a_gate_as_clock: assert property ( // see R6
        (clear_n && load_select_n && !clk_pin && clk_gate_n && !or_prev)
            |=> stage == {$past(stage[shifter_pkg::LAST_IDX-1:0]),
                $past(serial_in)})
        else $error("gate input not treated like clock input");

    a_clear_forces_low: assert property ( // see R8
        !clear_n |-> (serial_out == 1'b0) ##1 (stage == 8'h00))
        else $error("clear did not force stages low");

    a_hold_no_edge: assert property ( // see R9
        (clear_n && !edge_hit) |=> $stable(stage))
        else $error("stages changed without an active edge");

    a_resume_after_clear: assert property ( // see R10
        (!clear_n ##1 (clear_n && edge_hit && !load_select_n))
            |=> stage == $past(par_in))
        else $error("no load on first edge after clear");

    // pin acts as the clock while the gate is low
    a_pin_as_clock: assert property ( // see R5
        (clear_n && load_select_n && clk_pin && !clk_gate_n && !or_prev)
            |=> stage == {$past(stage[shifter_pkg::LAST_IDX-1:0]),
                $past(serial_in)})
        else $error("pin edge with gate low did not shift");

    // shift moves stage six onto serial_out
    a_shift_order: assert property ( // see R3
        (clear_n && edge_hit && load_select_n) |=>
            (!clear_n || serial_out == $past(stage[shifter_pkg::LAST_IDX-1])))
        else $error("serial_out did not take stage six after shift");

    a_steady_output: assert property ( // see R9
        (clear_n && !edge_hit) |=> (!clear_n || $stable(serial_out)))
        else $error("serial_out moved without an active edge");

    // clear overrides edges and pushes
    a_clear_beats_edge: assert property ( // see R8
        (!clear_n && edge_hit) |=> stage == shifter_pkg::CLEAR_VALUE)
        else $error("edge during clear changed the stages");

    a_clear_drops_push: assert property ( // see R8
        (!clear_n && edge_hit && !bit_valid) |=> !bit_valid)
        else $error("edge during clear pushed a bit");

    // ------------------------------------------------------------
    // output buffer assertions
    // ------------------------------------------------------------
    // an edge with room while clear is high always leaves a bit waiting
    a_push_after_edge: assert property ( // see R1
        (clear_n && edge_hit && bit_room) |=> bit_valid)
        else $error("active edge with room pushed no bit");

    a_first_bit_shown: assert property ( // see R1
        (clear_n && edge_hit && !bit_valid) |=>
            bit_data == stage[shifter_pkg::LAST_IDX])
        else $error("buffered bit differs from new last stage");

    // a refused bit must stand unchanged
    a_stream_stands: assert property ( // see R1
        (bit_valid && !bit_ready) |=> (bit_valid && $stable(bit_data)))
        else $error("buffered bit changed while not taken");

    a_full_stays: assert property ( // see R1
        (!bit_room && !bit_ready) |=> !bit_room)
        else $error("full buffer gained room without a pop");

    a_room_after_pop: assert property ( // see R1
        (!bit_room && bit_ready) |=> bit_room)
        else $error("pop from full buffer left no room");

    a_pop_empties: assert property ( // see R1
        (bit_valid && bit_room && bit_ready && !(clear_n && edge_hit))
            |=> !bit_valid)
        else $error("last bit popped but buffer still valid");

endmodule

// ### test/stream_consumer.sv
/*
 * Consumer of the buffered bit stream.
 * Assumes the bench supplies the stall and hold commands.
 */
`timescale 1ns/1ps
module stream_consumer (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic hold,
    output logic bit_ready
);
    logic [1:0] wait_cnt;
    // a stall lasts two cycles at most, so a steady stream never overflows
    always_ff @(posedge sys_clk) begin
        if (!rst_n || bit_ready) wait_cnt <= 2'h0;
        else if (wait_cnt != 2'h2) wait_cnt <= wait_cnt + 2'h1;
    end
    // hold refuses every bit, to fill the buffer
    assign bit_ready = hold ? 1'b0 : !(stall && wait_cnt != 2'h2);
endmodule

// ### test/testbench.sv
/*
 * Self-checking bench of the shifter: loads, shifts, swapped clock roles,
 * gated clock, clear and a full output buffer.
 * Assumes the design package and the stream consumer are compiled first.
 */
`timescale 1ns/1ps
module testbench;
    logic sys_clk, rst_n, clk_pin, clk_gate_n, load_select_n, serial_in;
    logic clear_n, bit_ready, stall, hold, exp_bit, chain;
    logic serial_out, bit_room, bit_valid, bit_data;
    logic [shifter_pkg::STAGE_COUNT-1:0] par_in, model;
    logic [31:0] rnd;
    logic q[$];
    int fails, tests_run;

    parallel_in_serial_out_shifter dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .clk_pin(clk_pin), .clk_gate_n(clk_gate_n),
        .load_select_n(load_select_n), .serial_in(serial_in),
        .par_in(par_in), .clear_n(clear_n), .serial_out(serial_out),
        .bit_room(bit_room), .bit_valid(bit_valid), .bit_data(bit_data),
        .bit_ready(bit_ready));
    stream_consumer sink (.sys_clk(sys_clk), .rst_n(rst_n), .stall(stall),
        .hold(hold), .bit_ready(bit_ready));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task test_done;
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // one active edge of the gated clock; sw swaps pin and gate roles
    task automatic step(input logic ld, input logic sw, input logic keep);
        logic [7:0] pi;
        logic si;
        rnd = lfsr(rnd);
        pi = rnd[7:0];
        si = chain ? serial_out : rnd[8];
        @(posedge sys_clk);
        load_select_n <= ld;
        par_in <= pi;
        serial_in <= si;
        stall <= rnd[9];
        if (sw) clk_gate_n <= 1'b0;
        else clk_pin <= 1'b0;
        repeat (2) @(posedge sys_clk);
        if (sw) clk_gate_n <= 1'b1;
        else clk_pin <= 1'b1;
        if (clear_n) model = ld ? {model[6:0], si} : pi;
        if (clear_n && keep) q.push_back(model[7]);
        repeat (2) @(posedge sys_clk);
        #1 check_bit(serial_out, model[7]);
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // buffered bits leave in push order
    always @(posedge sys_clk) begin
        if (rst_n && bit_valid === 1'b1 && bit_ready === 1'b1) begin
            exp_bit = q.size() ? q.pop_front() : 1'bx;
            check_bit(bit_data, exp_bit);
        end
    end

    initial begin
        #400000;
        fails++;
        test_done;
    end

    initial begin
        rst_n = 1'b0;
        clk_pin = 1'b1;
        clk_gate_n = 1'b0;
        load_select_n = 1'b1;
        serial_in = 1'b0;
        par_in = 8'h00;
        clear_n = 1'b1;
        stall = 1'b0;
        hold = 1'b0;
        chain = 1'b0;
        model = 8'h00;
        rnd = 32'h06ff_1032;
        fails = 0;
        tests_run = 0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 24; i++) step(i % 9 != 0, 1'b0, 1'b1);
        // swap roles: gate rises only while the pin is high
        @(posedge sys_clk) clk_gate_n <= 1'b1;
        @(posedge sys_clk) clk_pin <= 1'b0;
        for (int i = 0; i < 10; i++) step(i % 5 != 0, 1'b1, 1'b1);
        @(posedge sys_clk) clk_pin <= 1'b1;
        @(posedge sys_clk) clk_gate_n <= 1'b0;
        // gate high: pin pulses must not move the stages
        @(posedge sys_clk) clk_gate_n <= 1'b1;
        repeat (3) begin
            @(posedge sys_clk) clk_pin <= 1'b0;
            repeat (2) @(posedge sys_clk);
            clk_pin <= 1'b1;
        end
        @(posedge sys_clk) clk_gate_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 check_bit(serial_out, model[7]);
        // ring: serial_out fed back into serial_in, as in a chain
        chain = 1'b1;
        repeat (8) step(1'b1, 1'b0, 1'b1);
        chain = 1'b0;
        while (!model[7]) step(1'b0, 1'b0, 1'b1);
        // clear overrides a load edge
        @(posedge sys_clk) clear_n <= 1'b0;
        #1 check_bit(serial_out, 1'b0);
        model = 8'h00;
        step(1'b0, 1'b0, 1'b1);
        // release clear at the edge that raises the pin: load on that edge
        rnd = lfsr(rnd);
        @(posedge sys_clk) clk_pin <= 1'b0;
        load_select_n <= 1'b0;
        par_in <= rnd[7:0];
        repeat (2) @(posedge sys_clk);
        clear_n <= 1'b1;
        clk_pin <= 1'b1;
        model = rnd[7:0];
        q.push_back(model[7]);
        repeat (2) @(posedge sys_clk);
        #1 check_bit(serial_out, model[7]);
        // fill the buffer until it refuses, then drain it
        repeat (4) @(posedge sys_clk);
        hold <= 1'b1;
        step(1'b1, 1'b0, 1'b1);
        step(1'b1, 1'b0, 1'b1);
        check_bit(bit_room, 1'b0);
        step(1'b1, 1'b0, 1'b0);
        @(posedge sys_clk) hold <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1 check_bit(bit_valid, 1'b0);
        check_bit(q.size() == 0, 1'b1);
        test_done;
    end
endmodule
